/* File: core/dram_cycle_ctrl.sv */
`default_nettype none
// Summary of operation
// - Every row is refreshed within 8 ms by spacing one column-first refresh per row slot.
// - In a normal cycle the row strobe stays low at least 80 ns and at most 10000 ns.
// - The row strobe stays high at least 60 ns between low periods.
// - Nibble read or write column cycles are spaced at least 40 ns apart.
// - Nibble read-modify-write column cycles are spaced at least 65 ns apart.
// - A read-modify-write cycle lasts at least 175 ns, a plain cycle at least 150 ns.
// - For column-first refresh the column strobe falls at least 10 ns before the row strobe.
// - In column-first refresh the column strobe stays low at least 20 ns after row fall.
// - The refresh lead delay is applied only inside the column-first refresh sequence; the refresh hold comes from the row low time.
// - In a read the store strobe stays high until after both strobes have risen.
// - In read-modify-write the store strobe falls late enough after column and row fall.
// - In an early write the store strobe stays low at least 20 ns after column fall.
// - Write data is driven before the first column fall and from each later nibble column fall on, and held well past the later of column and store fall.
// - Row-to-column delay is kept at its minimum so the access time is preserved.
// - Column address is set up one column-high time before each column strobe fall.
module dram_cycle_ctrl
    import dram_timing_pkg::*;
#(
    parameter int ADDR_W    = 10,
    parameter int REF_GAP   = REFRESH_GAP_CYC
) (
    input  wire logic              mclk,
    input  wire logic              sys_rst,
    input  wire logic              reqValid,
    output logic                   reqReady,
    input  wire logic [1:0]        reqOp,
    input  wire logic              reqNibble,
    input  wire logic [2*ADDR_W-1:0] reqAddr,
    input  wire logic [3:0]        reqWdata,
    output logic [3:0]             rdData,
    output logic                   rdValid,
    output logic                   rowStrobe_n,
    output logic                   colStrobe_n,
    output logic                   storeStrobe_n,
    output logic [ADDR_W-1:0]      memAddr,
    output logic                   memDataOut,
    output logic                   memDataOe,
    input  wire logic              memDataIn
);
    typedef enum logic [6:0] {
        S_IDLE = 7'h01, S_ROW = 7'h02, S_COL = 7'h04, S_CHI = 7'h08,
        S_PRE  = 7'h10, S_RCOL = 7'h20, S_RROW = 7'h40
    } state_e;

    state_e state_r;
    logic [11:0] cnt_r;
    logic [11:0] rowCnt_r;
    logic [15:0] refCnt_r;
    logic refPend_r;
    logic [1:0] op_r;
    logic nib_r;
    logic [1:0] beat_r;
    logic [2*ADDR_W-1:0] addr_r;
    logic [3:0] wd_r;
    logic [3:0] rd_r;
    logic rdv_r;
    logic ras_r, cas_r, we_r, oe_r;
    logic [ADDR_W-1:0] ma_r;

    // Named decode of the current operation and timing thresholds.
    wire isRmw    = (op_r == OP_RMW);
    wire isWrite  = (op_r == OP_WRITE);
    wire [11:0] colLowNeed = isRmw ? 12'(COL_STORE_CYC + STORE_LOW_CYC) : 12'(COL_LOW_CYC);
    wire [11:0] nibNeed    = isRmw ? 12'(NIB_RMW_CYC) : 12'(NIB_CYC);
    wire [11:0] cycNeed    = isRmw ? 12'(RMW_CYCLE_CYC) : 12'(CYCLE_CYC);
    // A read-modify-write slot also waits until the store strobe has been low long enough.
    wire [11:0] rowNeed    = isRmw ? 12'(ROW_STORE_CYC + STORE_LOW_CYC) : 12'(ROW_LOW_CYC);
    wire lastBeat = !nib_r || (beat_r == 2'h3);
    // Row stays low past its minimum; each column slot spans the nibble spacing.
    wire colDone  = (cnt_r >= colLowNeed) && (cnt_r + 12'(COL_HIGH_CYC) >= nibNeed)
                    && ((!lastBeat && !isRmw) || rowCnt_r + 12'h001 >= rowNeed);
    // The row address is held a few cycles past row fall before the column replaces it.
    wire rowAddrHold = (state_r == S_ROW) && (cnt_r + 12'h002 < 12'(ROW_COL_CYC));
    wire preDone  = (cnt_r + 12'h001 >= 12'(ROW_PRE_CYC))
                    && (rowCnt_r >= cycNeed);
    wire refDue   = (refCnt_r >= 16'(REF_GAP - 1));

    assign reqReady = (state_r == S_IDLE) && !refPend_r;

    // Main sequencer; refresh has priority over a waiting request.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_r <= S_IDLE;
            cnt_r <= 12'h000;
            rowCnt_r <= 12'h000;
            op_r <= OP_READ;
            nib_r <= 1'b0;
            beat_r <= 2'h0;
            addr_r <= '0;
            wd_r <= 4'h0;
        end else begin
            cnt_r <= cnt_r + 12'h001;
            rowCnt_r <= rowCnt_r + 12'h001;
            unique case (state_r)
                S_IDLE: begin
                    if (refPend_r) begin
                        state_r <= S_RCOL;
                        cnt_r <= 12'h000;
                    end else if (reqValid) begin
                        op_r <= reqOp;
                        nib_r <= reqNibble;
                        addr_r <= reqAddr;
                        wd_r <= reqWdata;
                        beat_r <= 2'h0;
                        state_r <= S_ROW;
                        cnt_r <= 12'h000;
                        rowCnt_r <= 12'h000;
                    end
                end
                S_ROW: if (cnt_r + 12'h001 >= 12'(ROW_COL_CYC)) begin
                    state_r <= S_COL;
                    cnt_r <= 12'h000;
                end
                S_COL: if (colDone) begin
                    state_r <= lastBeat ? S_PRE : S_CHI;
                    cnt_r <= 12'h000;
                end
                S_CHI: if (cnt_r + 12'h001 >= 12'(COL_HIGH_CYC)) begin
                    beat_r <= beat_r + 2'h1;
                    state_r <= S_COL;
                    cnt_r <= 12'h000;
                end
                S_PRE: if (preDone) begin
                    state_r <= S_IDLE;
                end
                S_RCOL: if (cnt_r + 12'h001 >= 12'(REF_LEAD_CYC)) begin
                    state_r <= S_RROW;
                    cnt_r <= 12'h000;
                    rowCnt_r <= 12'h000;
                end
                S_RROW: if (cnt_r + 12'h001 >= 12'(ROW_LOW_CYC)) begin
                    state_r <= S_PRE;
                    cnt_r <= 12'h000;
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end

    // Refresh timer; the pending flag set wins over its clear in the same cycle.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            refCnt_r <= 16'h0000;
            refPend_r <= 1'b0;
        end else begin
            refCnt_r <= refDue ? 16'h0000 : refCnt_r + 16'h0001;
            if (refDue) refPend_r <= 1'b1;
            else if (state_r == S_RCOL) refPend_r <= 1'b0;
        end
    end

    // Pin drive. The store strobe is held high for reads until the row strobe is up again.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ras_r <= 1'b1;
            cas_r <= 1'b1;
            we_r <= 1'b1;
            oe_r <= 1'b0;
            ma_r <= '0;
            rd_r <= 4'h0;
            rdv_r <= 1'b0;
        end else begin
            rdv_r <= 1'b0;
            ras_r <= !(state_r == S_ROW || state_r == S_COL || state_r == S_CHI
                       || state_r == S_RROW);
            cas_r <= !(state_r == S_COL || state_r == S_RCOL || state_r == S_RROW);
            // Row address while idle and during rowAddrHold, column address from the end of rowAddrHold on.
            ma_r <= (state_r == S_IDLE) ? reqAddr[2*ADDR_W-1:ADDR_W]
                    : rowAddrHold ? addr_r[2*ADDR_W-1:ADDR_W]
                    : addr_r[ADDR_W-1:0];
            // Early write: low before column fall and kept low across every beat of the row,
            // so it falls ahead of the column strobe and rises with it on the step into precharge.
            // Read-modify-write: low only after the column and row delays have elapsed.
            we_r <= !((isWrite && (state_r == S_ROW || state_r == S_COL || state_r == S_CHI))
                      || (isRmw && state_r == S_COL && cnt_r >= 12'(COL_STORE_CYC)
                          && rowCnt_r >= 12'(ROW_STORE_CYC)));
            oe_r <= (op_r != OP_READ) && (state_r == S_ROW || state_r == S_COL);
            // Read data is taken once the column access time has fully elapsed.
            if (state_r == S_COL && cnt_r == 12'(COL_STORE_CYC)) begin
                rd_r[beat_r] <= memDataIn;
                if (lastBeat && op_r != OP_WRITE) rdv_r <= 1'b1;
            end
        end
    end

    assign rowStrobe_n   = ras_r;
    assign colStrobe_n   = cas_r;
    assign storeStrobe_n = we_r;
    assign memAddr       = ma_r;
    assign memDataOut    = wd_r[beat_r];
    assign memDataOe     = oe_r;
    assign rdData        = rd_r;
    assign rdValid       = rdv_r;

    // Row low time and precharge after any cycle, refresh or access.
    // The precharge count starts at ROW_PRE_CYC, since the row strobe rested high through reset,
    // and saturates so that a long idle spell cannot wrap it to a small value.
    logic [11:0] lowRun_r, highRun_r;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            lowRun_r <= 12'h000;
            highRun_r <= 12'(ROW_PRE_CYC);
        end else begin
            lowRun_r <= ras_r ? 12'h000 : lowRun_r + 12'h001;
            highRun_r <= !ras_r ? 12'h000 : (&highRun_r) ? highRun_r : highRun_r + 12'h001;
        end
    end
    sequence rowRise_s;
        !ras_r ##1 ras_r;
    endsequence
    rowlow_max_a: assert property (@(posedge mclk) disable iff (sys_rst)
        lowRun_r < 12'(ROW_LOW_MAX_CYC)) else $error("row strobe low too long");
    rowlow_min_a: assert property (@(posedge mclk) disable iff (sys_rst)
        rowRise_s |-> $past(lowRun_r) + 12'h001 >= 12'(ROW_LOW_CYC))
        else $error("row strobe low too short");
    precharge_min_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (ras_r ##1 !ras_r) |-> $past(highRun_r) >= 12'(ROW_PRE_CYC))
        else $error("precharge too short");
    ref_lead_a: assert property (@(posedge mclk) disable iff (sys_rst)
        ($fell(ras_r) && !cas_r) |-> $past(!cas_r, 2)) else $error("refresh lead short");
    ref_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
        ($fell(ras_r) && !cas_r) |-> !cas_r [*4]) else $error("refresh hold short");
    read_store_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (op_r == OP_READ && state_r != S_IDLE) |-> we_r) else $error("store low in read");
    early_write_a: assert property (@(posedge mclk) disable iff (sys_rst)
        ($fell(cas_r) && !we_r) |-> !we_r [*4]) else $error("early write hold short");
    rmw_store_a: assert property (@(posedge mclk) disable iff (sys_rst)
        ($fell(we_r) && isRmw) |-> $past(!cas_r, 4)) else $error("rmw store too early");
    // A refresh may wait behind a whole four-beat read-modify-write, about 76 cycles.
    refresh_due_a: assert property (@(posedge mclk) disable iff (sys_rst)
        $rose(refPend_r) |-> ##[1:100] (state_r == S_RCOL)) else $error("refresh late");
endmodule : dram_cycle_ctrl
`default_nettype wire

/* File: core/dram_timing_pkg.sv */
`default_nettype none
package dram_timing_pkg;
    // Clock rate and the timing figures in nanoseconds for the 80 ns grade, nibble part.
    localparam int CLK_PERIOD_NS     = 5;
    localparam int ROW_LOW_MIN_NS    = 80;
    localparam int ROW_LOW_MAX_NS    = 10000;
    localparam int ROW_PRE_MIN_NS    = 60;
    localparam int CYCLE_MIN_NS      = 150;
    localparam int RMW_CYCLE_MIN_NS  = 175;
    localparam int NIB_CYCLE_NS      = 40;
    localparam int NIB_RMW_CYCLE_NS  = 65;
    localparam int ROW_TO_COL_NS     = 22;
    localparam int COL_LOW_MIN_NS    = 20;
    localparam int COL_HIGH_MIN_NS   = 10;
    localparam int COL_TO_STORE_NS   = 20;
    localparam int ROW_TO_STORE_NS   = 80;
    localparam int STORE_LOW_NS      = 20;
    localparam int REF_COL_LEAD_NS   = 10;
    localparam int REF_COL_HOLD_NS   = 20;
    localparam int REFRESH_MS        = 8;
    localparam int REFRESH_ROWS      = 512;

    // Least times round up to whole cycles.
    function automatic int up(input int ns);
        return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    endfunction : up

    localparam int ROW_LOW_CYC   = up(ROW_LOW_MIN_NS);
    localparam int ROW_LOW_MAX_CYC = ROW_LOW_MAX_NS / CLK_PERIOD_NS;
    localparam int ROW_PRE_CYC   = up(ROW_PRE_MIN_NS);
    localparam int CYCLE_CYC     = up(CYCLE_MIN_NS);
    localparam int RMW_CYCLE_CYC = up(RMW_CYCLE_MIN_NS);
    localparam int NIB_CYC       = up(NIB_CYCLE_NS);
    localparam int NIB_RMW_CYC   = up(NIB_RMW_CYCLE_NS);
    localparam int ROW_COL_CYC   = up(ROW_TO_COL_NS);
    localparam int COL_LOW_CYC   = up(COL_LOW_MIN_NS);
    localparam int COL_HIGH_CYC  = up(COL_HIGH_MIN_NS);
    localparam int COL_STORE_CYC = up(COL_TO_STORE_NS);
    localparam int ROW_STORE_CYC = up(ROW_TO_STORE_NS);
    localparam int STORE_LOW_CYC = up(STORE_LOW_NS);
    localparam int REF_LEAD_CYC  = up(REF_COL_LEAD_NS);
    localparam int REF_HOLD_CYC  = up(REF_COL_HOLD_NS);
    // Refresh request spacing: interval divided over all rows, rounded down.
    localparam int REFRESH_GAP_CYC = (REFRESH_MS * 1000000 / CLK_PERIOD_NS) / REFRESH_ROWS;

    localparam logic [1:0] OP_READ  = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_RMW   = 2'h2;
endpackage : dram_timing_pkg
`default_nettype wire

/* File: tb/dram_device_model.sv */
`default_nettype none
module dram_device_model #(
    parameter int ADDR_W = 10
) (
    input  wire logic              rowStrobe_n,
    input  wire logic              colStrobe_n,
    input  wire logic              storeStrobe_n,
    input  wire logic [ADDR_W-1:0] memAddr,
    input  wire logic              memDataOut,
    input  wire logic              memDataOe,
    output logic                   memDataIn,
    output int                     violCnt,
    output int                     refCnt
);
    timeunit 1ns;
    timeprecision 100ps;
    bit                mem [int];
    logic [ADDR_W-1:0] row, col;
    realtime           tRowFall = -1e6, tRowRise = -1e6, tColFall = -1e6;
    bit                refMode, rmw, early, rowLow;
    int                beat, idx;
    initial begin
        memDataIn = 1'b0;
        violCnt = 0;
        refCnt = 0;
    end
    task viol(input string msg);
        violCnt++;
        $display("BAD %0t model: %s", $time, msg);
    endtask : viol
    // Data is taken a little after the later strobe, well inside the hold time.
    task store();
        #1;
        if (memDataOe !== 1'b1) viol("write data not driven");
        mem[idx] = memDataOut;
    endtask : store
    // Row fall opens a cycle; column already low means a column-first refresh.
    always @(negedge rowStrobe_n) begin
        if ($realtime - tRowRise < 60) viol("precharge short");
        if ($realtime - tRowFall < (rmw ? 175 : 150)) viol("row cycle short");
        refMode = !colStrobe_n;
        if (refMode && $realtime - tColFall < 10) viol("refresh lead short");
        if (refMode) refCnt++;
        tRowFall = $realtime;
        row = memAddr;
        beat = 0;
        rmw = 0;
        rowLow = 1;
    end
    always @(posedge rowStrobe_n) if (rowLow) begin
        rowLow = 0;
        tRowRise = $realtime;
        if (tRowRise - tRowFall < 80 || tRowRise - tRowFall > 10000) viol("row low width");
    end
    // Each column fall inside a row is one nibble beat; the column wraps in its low bits.
    always @(negedge colStrobe_n) begin
        if (!rowStrobe_n && $realtime - tColFall < (rmw ? 65 : 40)) viol("beat spacing");
        tColFall = $realtime;
        if (!rowStrobe_n) begin
            if (beat == 0) col = memAddr;
            idx = int'({row, col[ADDR_W-1:2], 2'(col[1:0] + beat[1:0])});
            beat++;
            early = !storeStrobe_n;
            if (early) store();
            else begin
                #15 memDataIn = mem[idx];
            end
        end
    end
    always @(negedge storeStrobe_n) if (!colStrobe_n && !rowStrobe_n) begin
        if ($realtime - tColFall < 15 || $realtime - tRowFall < 60) viol("rmw store early");
        rmw = 1;
        store();
    end
    always @(posedge storeStrobe_n) begin
        if (early && $realtime - tColFall < 15) viol("early write short");
    end
    // A released line shows the inverse of its last value, never a stale copy.
    always @(posedge colStrobe_n) begin
        if (refMode && !rowStrobe_n && $realtime - tRowFall < 15) viol("refresh hold");
        memDataIn = ~memDataIn;
    end
endmodule : dram_device_model
`default_nettype wire

/* File: tb/async_dram_cycle_timing_tb_top.sv */
`default_nettype none
module async_dram_cycle_timing_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import dram_timing_pkg::*;
    localparam int GAP = 200;
    logic        mclk, sys_rst, reqValid, reqReady, reqNibble, rdValid;
    logic        rowStrobe_n, colStrobe_n, storeStrobe_n, memDataOut, memDataOe, memDataIn;
    logic [1:0]  reqOp;
    logic [19:0] reqAddr;
    logic [3:0]  reqWdata, rdData, rd;
    logic [9:0]  memAddr;
    int          violCnt, refCnt, error_cnt, check_count, r0;
    dram_cycle_ctrl #(.ADDR_W(10), .REF_GAP(GAP)) i_dut (.mclk(mclk), .sys_rst(sys_rst),
        .reqValid(reqValid), .reqReady(reqReady), .reqOp(reqOp), .reqNibble(reqNibble),
        .reqAddr(reqAddr), .reqWdata(reqWdata), .rdData(rdData), .rdValid(rdValid),
        .rowStrobe_n(rowStrobe_n), .colStrobe_n(colStrobe_n), .storeStrobe_n(storeStrobe_n),
        .memAddr(memAddr), .memDataOut(memDataOut), .memDataOe(memDataOe), .memDataIn(memDataIn));
    dram_device_model #(.ADDR_W(10)) i_mem (.rowStrobe_n(rowStrobe_n), .colStrobe_n(colStrobe_n),
        .storeStrobe_n(storeStrobe_n), .memAddr(memAddr), .memDataOut(memDataOut),
        .memDataOe(memDataOe), .memDataIn(memDataIn), .violCnt(violCnt), .refCnt(refCnt));
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    task conclude();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : conclude
    task check4(input logic [3:0] got, input logic [3:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t data got %h expected %h", $time, got, exp);
        end
    endtask : check4
    task checkCnt(input int got, input int lo, input int hi);
        check_count++;
        if (got < lo || got > hi) begin
            error_cnt++;
            $display("BAD %0t count %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask : checkCnt
    // Request is held until a rising edge sees ready; reads then wait for the result pulse.
    task xfer(input logic [1:0] op, input logic nib, input logic [19:0] a, input logic [3:0] wd);
        int n;
        @(negedge mclk);
        {reqValid, reqOp, reqNibble, reqAddr, reqWdata} = {1'b1, op, nib, a, wd};
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (reqReady !== 1'b1 && n < 2000);
        @(negedge mclk);
        reqValid = 1'b0;
        while (op != OP_WRITE && rdValid !== 1'b1 && n < 4000) begin
            @(posedge mclk);
            n++;
        end
        if (n >= 2000 && op == OP_WRITE || n >= 4000) begin
            error_cnt++;
            $display("BAD %0t handshake timeout", $time);
            conclude();
        end
        rd = rdData;
    endtask : xfer
    // Single-bit write, read, read-modify-write and read back.
    task singleCycles();
        xfer(OP_WRITE, 1'b0, 20'h12345, 4'h1);
        xfer(OP_READ, 1'b0, 20'h12345, 4'h0);
        check4({3'h0, rd[0]}, 4'h1);
        xfer(OP_RMW, 1'b0, 20'h12345, 4'h0);
        check4({3'h0, rd[0]}, 4'h1);
        xfer(OP_READ, 1'b0, 20'h12345, 4'h0);
        check4({3'h0, rd[0]}, 4'h0);
    endtask : singleCycles
    // Four-beat bursts back to back, then a four-beat read-modify-write.
    task nibbleCycles();
        xfer(OP_WRITE, 1'b1, 20'h0a5c0, 4'ha);
        xfer(OP_READ, 1'b1, 20'h0a5c0, 4'h0);
        check4(rd, 4'ha);
        xfer(OP_RMW, 1'b1, 20'h0a5c0, 4'h5);
        check4(rd, 4'ha);
        xfer(OP_READ, 1'b1, 20'h0a5c0, 4'h0);
        check4(rd, 4'h5);
    endtask : nibbleCycles
    // Idle long enough for several refresh slots to come due.
    task refreshIdle();
        r0 = refCnt;
        repeat (2000) @(negedge mclk);
        checkCnt(refCnt - r0, 2000 / GAP - 1, 2000 / GAP + 1);
    endtask : refreshIdle
    initial begin
        {sys_rst, reqValid, reqOp, reqNibble, reqAddr, reqWdata} = {1'b1, 28'h0};
        error_cnt = 0;
        check_count = 0;
        repeat (5) @(negedge mclk);
        sys_rst = 1'b0;
        singleCycles();
        nibbleCycles();
        refreshIdle();
        singleCycles();
        checkCnt(violCnt, 0, 0);
        conclude();
    end
endmodule : async_dram_cycle_timing_tb_top
`default_nettype wire
